// file: rtl/gicr_defs.vh
// constants for the global interrupt and configuration register bank
// Function
// - read-only channel summary, one bit per channel, set while channel needs service
// - summary and three source-code registers reset to zero
// - channel sources count only when enabled by that channel's enables
// - 3-bit codes packed contiguously over 24 bits, channel 0 lowest
// - code 0 none, 1 to 4 by priority, 5 and 6 reserved, 7 lowest
// - code 1 for rx data ready or line error; cleared by draining or line-status read
// - code 2 for rx timeout, cleared by draining below trigger level
// - code 3 for transmit empty, cleared by interrupt-status read
// - code 4 for handshake change or character detect, cleared by their reads
// - timer timeout only as code 7 of channel 0
// - timer control read clears pending timer interrupt
// - timer interrupt gated by its enable bit, wake-up by sleep enables
// - wake-up interrupt only when all channels were asleep
// - summary register read clears pending wake-up interrupt
// - summary bit clears once no enabled source of that channel is pending
// - timer control: enable, start, function, clock source; upper bits zero
// - read/write sleep enable register, one bit per channel
// - broadcast control bit 0 sends configuration writes to all channels
// - soft-reset bits self-clear after a one is written
// - oversampling bit zero gives 16x, one gives 8x sampling
// - timer start, function and clock-source bit meanings
`ifndef GICR_DEFS_VH
`define GICR_DEFS_VH
`define GICR_NCH 8
`define GICR_CW 3
`define GICR_CODES_W 24
`define GICR_BYTE 8
`define GICR_CODE_A_LSB 0
`define GICR_CODE_B_LSB 8
`define GICR_CODE_C_LSB 16
`define GICR_A_SUM 8'h80
`define GICR_A_CODE_A 8'h81
`define GICR_A_CODE_B 8'h82
`define GICR_A_CODE_C 8'h83
`define GICR_A_TCTRL 8'h84
`define GICR_A_TSPARE 8'h85
`define GICR_A_TLO 8'h86
`define GICR_A_THI 8'h87
`define GICR_A_OVS 8'h88
`define GICR_A_SPARE 8'h89
`define GICR_A_SOFT 8'h8A
`define GICR_A_DOZE 8'h8B
`define GICR_A_REV 8'h8C
`define GICR_A_PID 8'h8D
`define GICR_A_BCAST 8'h8E
`define GICR_ZERO8 8'h00
`define GICR_ALL1 8'hFF
`define GICR_TC_W 4
`define GICR_TC_ZERO 4'h0
`define GICR_TC_IEN 0
`define GICR_TC_START 1
`define GICR_TC_FSEL 2
`define GICR_TC_CSRC 3
`define GICR_BC_BIT 0
`define GICR_BC_PAD 7'h00
`define GICR_CODE_NONE 3'h0
`define GICR_CODE_RX 3'h1
`define GICR_CODE_TMO 3'h2
`define GICR_CODE_TX 3'h3
`define GICR_CODE_MDM 3'h4
`define GICR_CODE_TMR 3'h7
// arbitrary identity values
`define GICR_REV_VAL 8'h03
`define GICR_PID_VAL 8'h5A
`endif

// file: rtl/gicr_chan_src.v
// per-channel interrupt source latches and priority encoder
`timescale 1ns/1ps
`include "gicr_defs.vh"
module gicr_chan_src #(
   parameter TMR_OK = 0
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_rx_lvl,
   input wire i_rx_tmo,
   input wire i_line_evt,
   input wire i_line_rd,
   input wire i_tx_evt,
   input wire i_isr_rd,
   input wire i_mdm_evt,
   input wire i_msr_rd,
   input wire i_chr_evt,
   input wire i_en_rx,
   input wire i_en_line,
   input wire i_en_tx,
   input wire i_en_mdm,
   input wire i_en_chr,
   input wire i_tmr_pend,
   output reg [2:0] o_code
);
reg line_r;
reg tx_r;
reg mdm_r;
reg chr_r;
////////////////////////////////////////////////////////////////////////
// sticky sources; a new event beats a clearing read in the same cycle
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      line_r <= 1'b0;
      tx_r <= 1'b0;
      mdm_r <= 1'b0;
      chr_r <= 1'b0;
   end
   else
   begin
      line_r <= i_line_evt | (line_r & ~i_line_rd);
      tx_r <= i_tx_evt | (tx_r & ~i_isr_rd);
      mdm_r <= i_mdm_evt | (mdm_r & ~i_msr_rd);
      chr_r <= i_chr_evt | (chr_r & ~i_isr_rd);
   end
end
////////////////////////////////////////////////////////////////////////
// highest priority enabled source wins; 5 and 6 never produced
always @*
begin
   o_code = `GICR_CODE_NONE;
   if ((i_en_rx & i_rx_lvl) | (i_en_line & line_r))
      o_code = `GICR_CODE_RX;
   else if (i_en_rx & i_rx_tmo)
      o_code = `GICR_CODE_TMO;
   else if (i_en_tx & tx_r)
      o_code = `GICR_CODE_TX;
   else if ((i_en_mdm & mdm_r) | (i_en_chr & chr_r))
      o_code = `GICR_CODE_MDM;
   else if ((TMR_OK != 0) && i_tmr_pend)
      o_code = `GICR_CODE_TMR;
end
endmodule // gicr_chan_src

// file: rtl/gicr_top.v
// global interrupt source and device configuration register bank
`timescale 1ns/1ps
`include "gicr_defs.vh"
module gicr_top (
   input wire i_clk,
   input wire i_rst,
   // host register port, same clock domain
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output wire [7:0] o_rdata,
   // per-channel levels and events from the channel logic
   input wire [7:0] i_rx_lvl,
   input wire [7:0] i_rx_tmo,
   input wire [7:0] i_line_evt,
   input wire [7:0] i_line_rd,
   input wire [7:0] i_thr_evt,
   input wire [7:0] i_tsr_evt,
   input wire [7:0] i_auto485,
   input wire [7:0] i_isr_rd,
   input wire [7:0] i_mdm_evt,
   input wire [7:0] i_msr_rd,
   input wire [7:0] i_chr_evt,
   // per-channel enables from each channel's enable register
   input wire [7:0] i_en_rx,
   input wire [7:0] i_en_line,
   input wire [7:0] i_en_tx,
   input wire [7:0] i_en_mdm,
   input wire [7:0] i_en_chr,
   // timer expiry and wake events
   input wire i_tmr_tmo,
   input wire i_wake,
   // global controls out to the rest of the device
   output wire o_irq,
   output wire o_tmr_start,
   output wire o_tmr_oneshot,
   output wire o_tmr_extclk,
   output wire [15:0] o_tmr_preset,
   output wire [7:0] o_ovs_8x,
   output wire [7:0] o_soft_clear,
   output wire [7:0] o_doze_en,
   output wire o_bcast_wr
);
////////////////////////////////////////////////////////////////////////
// address match shared by the read and write decoders
function hit;
   input [7:0] addr;
   input [7:0] offs;
   begin
      hit = (addr == offs);
   end
endfunction

reg [3:0] tctrl_r;
reg [7:0] tlo_r;
reg [7:0] thi_r;
reg [7:0] ovs_r;
reg [7:0] doze_r;
reg bcast_r;
reg [7:0] soft_r;
reg tmr_pend_r;
reg tmr_pend_nxt;
reg wake_pend_r;
reg wake_pend_nxt;
reg [7:0] sum_r;
reg [23:0] code_r;
reg [7:0] rdata_r;
reg [7:0] rdata_nxt;
reg irq_r;
wire [23:0] codes;
wire [7:0] sum_nxt;
wire [7:0] tx_evt;
wire rd_sum;
wire rd_tctrl;
wire tmr_gate;

assign rd_sum = i_rd & hit(i_addr, `GICR_A_SUM);
assign rd_tctrl = i_rd & hit(i_addr, `GICR_A_TCTRL);
// masked timer pending as seen by channel 0
assign tmr_gate = tmr_pend_r & tctrl_r[`GICR_TC_IEN];

////////////////////////////////////////////////////////////////////////
// transmit empty source follows the shift register in auto RS-485 mode
assign tx_evt = (i_auto485 & i_tsr_evt) | (~i_auto485 & i_thr_evt);

////////////////////////////////////////////////////////////////////////
// one source encoder per channel; only channel 0 sees the timer
genvar g;
generate
   for (g = 0; g < `GICR_NCH; g = g + 1)
   begin : ch
      wire [2:0] code_w;
      gicr_chan_src #(
         .TMR_OK((g == 0) ? 1 : 0)
      ) u_src (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_rx_lvl(i_rx_lvl[g]),
         .i_rx_tmo(i_rx_tmo[g]),
         .i_line_evt(i_line_evt[g]),
         .i_line_rd(i_line_rd[g]),
         .i_tx_evt(tx_evt[g]),
         .i_isr_rd(i_isr_rd[g]),
         .i_mdm_evt(i_mdm_evt[g]),
         .i_msr_rd(i_msr_rd[g]),
         .i_chr_evt(i_chr_evt[g]),
         .i_en_rx(i_en_rx[g]),
         .i_en_line(i_en_line[g]),
         .i_en_tx(i_en_tx[g]),
         .i_en_mdm(i_en_mdm[g]),
         .i_en_chr(i_en_chr[g]),
         .i_tmr_pend(tmr_gate),
         .o_code(code_w)
      );
      // contiguous packing, so channels 2 and 5 span two bytes
      assign codes[g*`GICR_CW +: `GICR_CW] = code_w;
      // any non-zero code means the channel wants service
      assign sum_nxt[g] = |code_w;
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// global status snapshot, refreshed every cycle
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      sum_r <= `GICR_ZERO8;
      code_r <= {`GICR_CODES_W{1'b0}};
   end
   else
   begin
      sum_r <= sum_nxt;
      code_r <= codes;
   end
end

////////////////////////////////////////////////////////////////////////
// timer pending: expiry beats a clearing read in the same cycle
always @*
begin
   tmr_pend_nxt = tmr_pend_r;
   if (rd_tctrl)
      tmr_pend_nxt = 1'b0;
   if (i_tmr_tmo)
      tmr_pend_nxt = 1'b1;
end

////////////////////////////////////////////////////////////////////////
// timer pending flag; kept unmasked so a late enable still reports it
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      tmr_pend_r <= 1'b0;
   end
   else
   begin
      tmr_pend_r <= tmr_pend_nxt;
   end
end

////////////////////////////////////////////////////////////////////////
// wake-up counts only when every channel had been put to doze
wire all_dozing;
assign all_dozing = (doze_r == `GICR_ALL1);

// wake pending: a wake event beats a clearing summary read
always @*
begin
   wake_pend_nxt = wake_pend_r;
   if (rd_sum)
      wake_pend_nxt = 1'b0;
   if (i_wake & all_dozing)
      wake_pend_nxt = 1'b1;
end

always @(posedge i_clk)
begin
   if (i_rst)
   begin
      wake_pend_r <= 1'b0;
   end
   else
   begin
      wake_pend_r <= wake_pend_nxt;
   end
end

////////////////////////////////////////////////////////////////////////
// write strobes, one per writable register
wire wr_tctrl;
wire wr_tlo;
wire wr_thi;
wire wr_ovs;
wire wr_soft;
wire wr_doze;
wire wr_bcast;

assign wr_tctrl = i_wr & hit(i_addr, `GICR_A_TCTRL);
assign wr_tlo = i_wr & hit(i_addr, `GICR_A_TLO);
assign wr_thi = i_wr & hit(i_addr, `GICR_A_THI);
assign wr_ovs = i_wr & hit(i_addr, `GICR_A_OVS);
assign wr_soft = i_wr & hit(i_addr, `GICR_A_SOFT);
assign wr_doze = i_wr & hit(i_addr, `GICR_A_DOZE);
assign wr_bcast = i_wr & hit(i_addr, `GICR_A_BCAST);

////////////////////////////////////////////////////////////////////////
// timer control; only the four defined bits are stored
always @(posedge i_clk)
begin
   if (i_rst)
      tctrl_r <= `GICR_TC_ZERO;
   else if (wr_tctrl)
      tctrl_r <= i_wdata[`GICR_TC_W-1:0];
end

////////////////////////////////////////////////////////////////////////
// timer preset bytes, handed to the counter as one 16-bit value
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      tlo_r <= `GICR_ZERO8;
      thi_r <= `GICR_ZERO8;
   end
   else
   begin
      if (wr_tlo)
         tlo_r <= i_wdata;
      if (wr_thi)
         thi_r <= i_wdata;
   end
end

////////////////////////////////////////////////////////////////////////
// per-channel sampling rate select
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      ovs_r <= `GICR_ZERO8;
   end
   else if (wr_ovs)
   begin
      ovs_r <= i_wdata;
   end
end

////////////////////////////////////////////////////////////////////////
// doze enables; all ones arms the wake-up report
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      doze_r <= `GICR_ZERO8;
   end
   else if (wr_doze)
   begin
      doze_r <= i_wdata;
   end
end

////////////////////////////////////////////////////////////////////////
// broadcast flag; upper bits are not stored and read as zero
always @(posedge i_clk)
begin
   if (i_rst)
   begin
      bcast_r <= 1'b0;
   end
   else if (wr_bcast)
   begin
      bcast_r <= i_wdata[`GICR_BC_BIT];
   end
end

////////////////////////////////////////////////////////////////////////
// soft reset is a one-cycle pulse; the register holds a written one for that cycle only,
// so channel logic must act on the pulse, not poll a level
always @(posedge i_clk)
begin
   if (i_rst)
      soft_r <= `GICR_ZERO8;
   else if (wr_soft)
      soft_r <= i_wdata;
   else
      soft_r <= `GICR_ZERO8;
end

////////////////////////////////////////////////////////////////////////
// read data select; write-only and spare locations read as zero
always @*
begin
   rdata_nxt = `GICR_ZERO8;
   case (i_addr)
      `GICR_A_SUM: rdata_nxt = sum_r;
      `GICR_A_CODE_A: rdata_nxt = code_r[`GICR_CODE_A_LSB +: `GICR_BYTE];
      `GICR_A_CODE_B: rdata_nxt = code_r[`GICR_CODE_B_LSB +: `GICR_BYTE];
      `GICR_A_CODE_C: rdata_nxt = code_r[`GICR_CODE_C_LSB +: `GICR_BYTE];
      `GICR_A_TCTRL: rdata_nxt = {`GICR_TC_ZERO, tctrl_r};
      `GICR_A_TSPARE: rdata_nxt = `GICR_ZERO8;
      `GICR_A_TLO: rdata_nxt = tlo_r;
      `GICR_A_THI: rdata_nxt = thi_r;
      `GICR_A_OVS: rdata_nxt = ovs_r;
      `GICR_A_SPARE: rdata_nxt = `GICR_ZERO8;
      `GICR_A_SOFT: rdata_nxt = `GICR_ZERO8;
      `GICR_A_DOZE: rdata_nxt = doze_r;
      `GICR_A_REV: rdata_nxt = `GICR_REV_VAL;
      `GICR_A_PID: rdata_nxt = `GICR_PID_VAL;
      `GICR_A_BCAST: rdata_nxt = {`GICR_BC_PAD, bcast_r};
      default: rdata_nxt = `GICR_ZERO8;
   endcase
end

////////////////////////////////////////////////////////////////////////
// read data is captured on the read strobe and stands until the next
// read, so the host may pick it up any time after that edge
always @(posedge i_clk)
begin
   if (i_rst)
      rdata_r <= `GICR_ZERO8;
   else if (i_rd)
      rdata_r <= rdata_nxt;
end

////////////////////////////////////////////////////////////////////////
// shared interrupt; built from next-state values so it rises together
// with the summary register instead of one cycle behind it
always @(posedge i_clk)
begin
   if (i_rst)
      irq_r <= 1'b0;
   else
      irq_r <= (|sum_nxt) | wake_pend_nxt;
end

////////////////////////////////////////////////////////////////////////
// outputs, each taken straight from a register
assign o_rdata = rdata_r;
assign o_irq = irq_r;
assign o_tmr_start = tctrl_r[`GICR_TC_START];
assign o_tmr_oneshot = tctrl_r[`GICR_TC_FSEL];
assign o_tmr_extclk = tctrl_r[`GICR_TC_CSRC];
assign o_tmr_preset = {thi_r, tlo_r};
assign o_ovs_8x = ovs_r;
assign o_soft_clear = soft_r;
assign o_doze_en = doze_r;
assign o_bcast_wr = bcast_r;

endmodule // gicr_top

// file: testbench/gicr_chk_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module gicr_chk (
   input wire i_clk,
   input wire i_rst,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire [7:0] i_rx_lvl,
   input wire [7:0] i_en_rx,
   input wire o_irq,
   input wire o_tmr_start,
   input wire o_tmr_oneshot,
   input wire o_bcast_wr,
   input wire [7:0] o_soft_clear,
   input wire [7:0] o_doze_en
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////
   // writes land one edge later; sleep enable then holds
   doze_write_a: assert property (
      i_wr && i_addr == 8'h8B |=> o_doze_en == $past(i_wdata))
      else $error("sleep enable write lost");
   doze_hold_a: assert property (
      !i_wr |=> $stable(o_doze_en)) else $error("sleep enable drifted");
   timer_bits_a: assert property (
      i_wr && i_addr == 8'h84 |=> o_tmr_start == $past(i_wdata[1])
      && o_tmr_oneshot == $past(i_wdata[2])) else $error("timer bits");
   bcast_write_a: assert property (
      i_wr && i_addr == 8'h8E |=> o_bcast_wr == $past(i_wdata[0]))
      else $error("broadcast bit");
   // soft clear is a single pulse, never a level
   soft_pulse_a: assert property (
      i_wr && i_addr == 8'h8A |=> o_soft_clear == $past(i_wdata)
      ##1 o_soft_clear == 8'h00) else $error("soft clear pulse");
   soft_idle_a: assert property (
      !i_wr |=> o_soft_clear == 8'h00) else $error("soft clear stuck");
   irq_raise_a: assert property (
      (i_rx_lvl & i_en_rx) != 8'h00 |-> ##[0:2] o_irq)
      else $error("irq missing");
   irq_masked_a: assert property (
      $past(i_rx_lvl & ~i_en_rx, 1) == i_rx_lvl && i_en_rx == 8'h00
      && i_rx_lvl != 8'h00 && !o_irq |=> !o_irq) else $error("masked irq");
   cover property (i_wr && i_addr == 8'h8A);
   cover property (o_irq);
   cover property (o_bcast_wr);
endmodule // gicr_chk
bind gicr_top gicr_chk chk_u (.*);

// file: testbench/gicr_host.sv
// host processor model on the parallel register port
`timescale 1ns/1ps
module gicr_host (
   input wire i_clk,
   input wire [7:0] i_rdata,
   output logic [7:0] o_addr = 8'h00,
   output logic [7:0] o_wdata = 8'h00,
   output logic o_wr = 1'b0,
   output logic o_rd = 1'b0
);
   // one strobe cycle, idle cycle before it so strobes never merge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = w;
      o_rd = !w;
      @(posedge i_clk);
      #1;
      q = i_rdata;
      o_wr = 1'b0;
      o_rd = 1'b0;
   endtask
endmodule // gicr_host

// file: testbench/gicr_top_tb_top.sv
// self-checking bench for the global interrupt register bank
`timescale 1ns/1ps
module gicr_top_tb_top;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_wr, i_rd, o_irq, o_tmr_start, o_tmr_oneshot, o_tmr_extclk;
   logic i_tmr_tmo, i_wake, o_bcast_wr;
   logic [7:0] i_addr, i_wdata, o_rdata, o_ovs_8x, o_soft_clear;
   logic [7:0] o_doze_en, en, q, rv, tx_shift_reg, a485;
   logic [15:0] o_tmr_preset;
   logic [7:0] ev [6];
   logic [7:0] cl [3];
   int err_total = 0;
   int checked = 0;
   int ch;
   int code_of [6] = '{1, 2, 1, 3, 4, 4};
   int clr_of [6] = '{0, 0, 0, 1, 2, 1};
   wire [7:0] i_rx_lvl = ev[0], i_rx_tmo = ev[1], i_line_evt = ev[2];
   wire [7:0] i_thr_evt = ev[3], i_mdm_evt = ev[4], i_chr_evt = ev[5];
   wire [7:0] i_line_rd = cl[0], i_isr_rd = cl[1], i_msr_rd = cl[2];
   wire [7:0] i_tsr_evt = tx_shift_reg, i_auto485 = a485;
   wire [7:0] i_en_rx = en, i_en_line = en, i_en_tx = en;
   wire [7:0] i_en_mdm = en, i_en_chr = en;
   gicr_host host_u (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   gicr_top dut_u (.*);
   always #5 i_clk = ~i_clk;
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, e);
      host_u.xfer(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // expected summary bit and packed 3-bit code of one channel
   task automatic codes(input int c, k);
      logic [23:0] x;
      x = 24'(k) << (3 * c);
      rdc(8'h80, (k != 0) ? 8'h01 << c : 8'h00);
      rdc(8'h81, x[7:0]);
      rdc(8'h82, x[15:8]);
      rdc(8'h83, x[23:16]);
   endtask
   task automatic pulse_done();
      @(posedge i_clk);
      #1;
      cl = '{default: 8'h00};
      ev[2] = 8'h00;
      ev[3] = 8'h00;
      ev[4] = 8'h00;
      ev[5] = 8'h00;
      tx_shift_reg = 8'h00;
      i_tmr_tmo = 1'b0;
      i_wake = 1'b0;
   endtask
   task automatic give_verdict();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #500000;
      err_total++;
      give_verdict();
   end
   initial
   begin
      ev = '{default: 8'h00};
      cl = '{default: 8'h00};
      en = 8'hFF;
      tx_shift_reg = 8'h00;
      a485 = 8'h00;
      i_tmr_tmo = 1'b0;
      i_wake = 1'b0;
      void'($urandom(64886));
      repeat (10) @(posedge i_clk);
      #1 i_rst = 1'b0;
      codes(0, 0);
      rdc(8'h85, 8'h00);
      // every source kind on a random channel, then its own clearing
      for (int k = 0; k < 6; k++)
      begin
         ch = $urandom % 8;
         ev[k][ch] = 1'b1;
         if (k > 1) pulse_done();
         codes(ch, code_of[k]);
         chk("irq", 8'h01, {7'h00, o_irq});
         if (k < 2) ev[k][ch] = 1'b0;
         else cl[clr_of[k]][ch] = 1'b1;
         pulse_done();
         codes(ch, 0);
      end
      // rx level and transmit empty together, rx outranks
      ev[0][5] = 1'b1;
      ev[3][5] = 1'b1;
      pulse_done();
      codes(5, 1);
      ev[0][5] = 1'b0;
      codes(5, 3);
      cl[1][5] = 1'b1;
      pulse_done();
      // auto RS-485: shift-register empty replaces holding-register empty
      a485[6] = 1'b1;
      ev[3][6] = 1'b1;
      pulse_done();
      codes(6, 0);
      tx_shift_reg[6] = 1'b1;
      pulse_done();
      codes(6, 3);
      cl[1][6] = 1'b1;
      pulse_done();
      codes(6, 0);
      a485 = 8'h00;
      en = 8'h00;
      ev[0][2] = 1'b1;
      codes(2, 0);
      ev[0][2] = 1'b0;
      en = 8'hFF;
      // timer expiry with its enable off stays hidden
      wr(8'h84, 8'h06);
      chk("start", 8'h01, {7'h00, o_tmr_start});
      chk("oneshot", 8'h01, {7'h00, o_tmr_oneshot});
      i_tmr_tmo = 1'b1;
      pulse_done();
      codes(0, 0);
      rdc(8'h84, 8'h06);
      // timer with enable and external clock, cleared by its read
      wr(8'h84, 8'hF9);
      chk("extclk", 8'h01, {7'h00, o_tmr_extclk});
      chk("stop", 8'h00, {7'h00, o_tmr_start});
      i_tmr_tmo = 1'b1;
      pulse_done();
      codes(0, 7);
      rdc(8'h84, 8'h09);
      codes(0, 0);
      rv = 8'($urandom);
      wr(8'h86, rv);
      wr(8'h87, ~rv);
      chk("preset lo", rv, o_tmr_preset[7:0]);
      chk("preset hi", ~rv, o_tmr_preset[15:8]);
      rdc(8'h86, rv);
      wr(8'h88, rv);
      chk("ovs", rv, o_ovs_8x);
      rdc(8'h88, rv);
      wr(8'h8B, rv);
      rdc(8'h8B, rv);
      chk("doze", rv, o_doze_en);
      wr(8'h8E, 8'hFF);
      rdc(8'h8E, 8'h01);
      chk("bcast", 8'h01, {7'h00, o_bcast_wr});
      wr(8'h8A, rv);
      chk("soft", rv, o_soft_clear);
      @(posedge i_clk);
      #1;
      chk("soft end", 8'h00, o_soft_clear);
      rdc(8'h8A, 8'h00);
      // wake-up only after every channel was put to sleep
      wr(8'h8B, 8'h7F);
      i_wake = 1'b1;
      pulse_done();
      chk("no wake", 8'h00, {7'h00, o_irq});
      wr(8'h8B, 8'hFF);
      i_wake = 1'b1;
      pulse_done();
      chk("wake irq", 8'h01, {7'h00, o_irq});
      rdc(8'h80, 8'h00);
      chk("wake clr", 8'h00, {7'h00, o_irq});
      give_verdict();
   end
endmodule // gicr_top_tb_top
